// File: design/jdt_tap.sv
// Test access port, boundary cells, identity register and reset control.
// Assumes TCK is much slower than I_SYS_CLK; all pins are sampled here.
`timescale 1ns/1ns
module jdt_tap
  import jdt_pkg::*;
#(
  parameter int BSC_PINS = 8,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  // Arbitrary identity value; top nibble is the revision field
  parameter logic [WORD_W-1:0] ID_CODE = 32'h1000_0001
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic I_TRSTN,
  output logic O_TDO,
  output logic O_TDO_OE,
  input wire logic I_POR_PIN_N,
  input wire logic I_EMU_MODE_SEL,
  output logic O_CHIP_RESET_N,
  output logic O_DEBUG_RESET_N,
  output logic O_RESET_HOLD,
  input wire logic I_ID_HALF_SEL,
  output logic [HALF_W-1:0] O_ID_HALF,
  input wire logic [BSC_PINS-1:0] I_CORE_OUT,
  input wire logic [BSC_PINS-1:0] I_CORE_OE,
  output logic [BSC_PINS-1:0] O_CORE_IN,
  input wire logic [BSC_PINS-1:0] I_PIN_IN,
  output logic [BSC_PINS-1:0] O_PIN_OUT,
  output logic [BSC_PINS-1:0] O_PIN_OE,
  output logic O_RX_VALID,
  input wire logic I_RX_READY,
  output logic [WORD_W-1:0] O_RX_DATA
);
  localparam int BS_W = BSC_PINS * CELLS_PER_PIN;

  jdt_pins_type pins_in;
  jdt_pins_type pin_s1_reg;
  jdt_pins_type pin_s2_reg;
  logic tck_s3_reg;
  logic [BSC_PINS-1:0] pad_s1_reg;
  logic [BSC_PINS-1:0] pad_s2_reg;
  logic tck_rise;
  logic tck_fall;
  logic tap_rstn;
  jdt_tap_state_type state_reg;
  jdt_tap_state_type state_next;
  logic [IR_W-1:0] ir_reg;
  logic [IR_W-1:0] ir_sh_reg;
  logic tdi_cap_reg;
  logic sh_pend_reg;
  logic ir_col;
  logic [WORD_W-1:0] word_sh_reg;
  logic [BS_W-1:0] bs_sh_reg;
  logic [BS_W-1:0] bs_cap;
  logic [BS_W-1:0] bs_lat_reg;
  logic byp_reg;
  logic sel_word;
  logic sel_bs;
  logic dbg_class;
  logic drive_latch;
  logic drive_off;
  logic bit0;
  logic bit1;
  logic cap_bit0;
  logic tdo_reg;
  logic fifo_in_ready;
  logic fifo_push;
  logic rst_cmd_reg;
  logic hold_reg;
  logic [HALF_W-1:0] id_half_reg;

  // ------------------------------------------------------------
  // Pin synchronisers and TCK edge detection
  // ------------------------------------------------------------
  assign pins_in = '{I_TCK, I_TMS, I_TDI, I_TRSTN, I_POR_PIN_N, I_EMU_MODE_SEL};

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pin_s1_reg <= PINS_RESET;
      pin_s2_reg <= PINS_RESET;
      tck_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pins_in;
      pin_s2_reg <= pin_s1_reg;
      tck_s3_reg <= pin_s2_reg.tck;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pad_s1_reg <= '0;
      pad_s2_reg <= '0;
    end else begin
      pad_s1_reg <= I_PIN_IN;
      pad_s2_reg <= pad_s1_reg;
    end
  end

  assign tck_rise = pin_s2_reg.tck & ~tck_s3_reg;
  assign tck_fall = ~pin_s2_reg.tck & tck_s3_reg;
  assign O_CORE_IN = pad_s2_reg;

  // Raw TRST clears the TAP at once, independent of any clock
  assign tap_rstn = I_RSTN & I_TRSTN;

  // ------------------------------------------------------------
  // TAP state machine
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_TLR: state_next = pin_s2_reg.tms ? ST_TLR : ST_RTI;
      ST_RTI: state_next = pin_s2_reg.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = pin_s2_reg.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = pin_s2_reg.tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = pin_s2_reg.tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = pin_s2_reg.tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: state_next = pin_s2_reg.tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = pin_s2_reg.tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = pin_s2_reg.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = pin_s2_reg.tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_next = pin_s2_reg.tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = pin_s2_reg.tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = pin_s2_reg.tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: state_next = pin_s2_reg.tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = pin_s2_reg.tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = pin_s2_reg.tms ? ST_SEL_DR : ST_RTI;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge tap_rstn) begin
    if (!tap_rstn) begin
      state_reg <= ST_TLR;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // TDI is held from the rise; the shift uses it at the next fall
  always_ff @(posedge I_SYS_CLK or negedge tap_rstn) begin
    if (!tap_rstn) begin
      tdi_cap_reg <= 1'b0;
      sh_pend_reg <= 1'b0;
    end else if (tck_rise) begin
      tdi_cap_reg <= pin_s2_reg.tdi;
      sh_pend_reg <= (state_reg == ST_SH_DR) || (state_reg == ST_SH_IR);
    end
  end

  assign ir_col = (state_reg >= ST_CAP_IR);

  // ------------------------------------------------------------
  // Instruction register and decode
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge tap_rstn) begin
    if (!tap_rstn) begin
      ir_sh_reg <= IR_CAPTURE;
      ir_reg <= INS_IDCODE;
    end else if (state_reg == ST_TLR) begin
      ir_reg <= INS_IDCODE;
    end else if (tck_rise && state_reg == ST_CAP_IR) begin
      ir_sh_reg <= IR_CAPTURE;
    end else if (tck_fall && sh_pend_reg && ir_col) begin
      ir_sh_reg <= {tdi_cap_reg, ir_sh_reg[IR_W-1:1]};
    end else if (tck_fall && state_reg == ST_UPD_IR) begin
      ir_reg <= ir_sh_reg;
    end
  end

  assign sel_word = (ir_reg == INS_IDCODE) || (ir_reg == INS_DBG_DATA);
  assign sel_bs = (ir_reg == INS_SAMPLE) || (ir_reg == INS_EXTEST);
  assign dbg_class = (ir_reg == INS_DBG_DATA) || (ir_reg == INS_DBG_RST_ON)
                     || (ir_reg == INS_DBG_RST_OFF);
  assign drive_latch = (ir_reg == INS_EXTEST) || (ir_reg == INS_CLAMP);
  assign drive_off = (ir_reg == INS_HIGHZ);

  // ------------------------------------------------------------
  // Data registers: identity / debug word, bypass
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge tap_rstn) begin
    if (!tap_rstn) begin
      word_sh_reg <= '0;
    end else if (tck_rise && state_reg == ST_CAP_DR && sel_word) begin
      if (ir_reg == INS_IDCODE) begin
        word_sh_reg <= ID_CODE;
      end else begin
        word_sh_reg <= {{(WORD_W-1){1'b0}}, fifo_in_ready};
      end
    end else if (tck_fall && sh_pend_reg && !ir_col && sel_word) begin
      word_sh_reg <= {tdi_cap_reg, word_sh_reg[WORD_W-1:1]};
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge tap_rstn) begin
    if (!tap_rstn) begin
      byp_reg <= 1'b0;
    end else if (tck_rise && state_reg == ST_CAP_DR) begin
      byp_reg <= 1'b0;
    end else if (tck_fall && sh_pend_reg && !ir_col) begin
      byp_reg <= tdi_cap_reg;
    end
  end

  // ------------------------------------------------------------
  // Boundary cells, one group per pin
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < BSC_PINS; gi++) begin : g_cell
      assign bs_cap[gi*CELLS_PER_PIN + CELL_IN] = pad_s2_reg[gi];
      assign bs_cap[gi*CELLS_PER_PIN + CELL_OUT] = I_CORE_OUT[gi];
      assign bs_cap[gi*CELLS_PER_PIN + CELL_CTRL] = I_CORE_OE[gi];

      always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          O_PIN_OUT[gi] <= 1'b0;
          O_PIN_OE[gi] <= 1'b0;
        end else if (drive_off) begin
          O_PIN_OUT[gi] <= 1'b0;
          O_PIN_OE[gi] <= 1'b0;
        end else if (drive_latch) begin
          O_PIN_OUT[gi] <= bs_lat_reg[gi*CELLS_PER_PIN + CELL_OUT];
          O_PIN_OE[gi] <= bs_lat_reg[gi*CELLS_PER_PIN + CELL_CTRL];
        end else begin
          O_PIN_OUT[gi] <= I_CORE_OUT[gi];
          O_PIN_OE[gi] <= I_CORE_OE[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_SYS_CLK or negedge tap_rstn) begin
    if (!tap_rstn) begin
      bs_sh_reg <= '0;
    end else if (tck_rise && state_reg == ST_CAP_DR && sel_bs) begin
      bs_sh_reg <= bs_cap;
    end else if (tck_fall && sh_pend_reg && !ir_col && sel_bs) begin
      bs_sh_reg <= {tdi_cap_reg, bs_sh_reg[BS_W-1:1]};
    end
  end

  // Latch survives TRST so a clamped pattern is not lost mid-test
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      bs_lat_reg <= '0;
    end else if (tck_fall && state_reg == ST_UPD_DR && sel_bs) begin
      bs_lat_reg <= bs_sh_reg;
    end
  end

  // ------------------------------------------------------------
  // TDO: selected path bit, edge chosen by instruction class
  // ------------------------------------------------------------
  always_comb begin
    if (ir_col) begin
      bit0 = ir_sh_reg[0];
      bit1 = ir_sh_reg[1];
      cap_bit0 = IR_CAPTURE[0];
    end else if (sel_word) begin
      bit0 = word_sh_reg[0];
      bit1 = word_sh_reg[1];
      cap_bit0 = (ir_reg == INS_IDCODE) ? ID_CODE[0] : fifo_in_ready;
    end else if (sel_bs) begin
      bit0 = bs_sh_reg[0];
      bit1 = bs_sh_reg[1];
      cap_bit0 = bs_cap[0];
    end else begin
      bit0 = byp_reg;
      bit1 = tdi_cap_reg;
      cap_bit0 = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge tap_rstn) begin
    if (!tap_rstn) begin
      tdo_reg <= 1'b0;
    end else if (dbg_class && tck_rise) begin
      if (state_reg == ST_CAP_DR || state_reg == ST_CAP_IR) begin
        tdo_reg <= cap_bit0;
      end else begin
        tdo_reg <= bit1;
      end
    end else if (!dbg_class && tck_fall) begin
      tdo_reg <= sh_pend_reg ? bit1 : bit0;
    end
  end

  assign O_TDO = tdo_reg;
  assign O_TDO_OE = (state_reg == ST_SH_DR) || (state_reg == ST_SH_IR);

  // ------------------------------------------------------------
  // Debug data words into the receive FIFO
  // ------------------------------------------------------------
  assign fifo_push = tck_fall && (state_reg == ST_UPD_DR) && (ir_reg == INS_DBG_DATA);

  jdt_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) jdt_fifo_inst (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(word_sh_reg),
    .o_out_valid(O_RX_VALID),
    .i_out_ready(I_RX_READY),
    .o_out_data(O_RX_DATA)
  );

  // ------------------------------------------------------------
  // Reset control
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_cmd_reg <= 1'b0;
    end else if (tck_fall && state_reg == ST_UPD_IR) begin
      if (ir_sh_reg == INS_DBG_RST_ON) begin
        rst_cmd_reg <= 1'b1;
      end else if (ir_sh_reg == INS_DBG_RST_OFF) begin
        rst_cmd_reg <= 1'b0;
      end
    end
  end

  // Hold is left only by power-on reset, and not while TRST and emulation select are both low
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hold_reg <= 1'b0;
    end else if (!pin_s2_reg.emu_sel && !pin_s2_reg.trst_n) begin
      hold_reg <= 1'b1;
    end else if (!pin_s2_reg.por_n) begin
      hold_reg <= 1'b0;
    end
  end

  assign O_RESET_HOLD = hold_reg;
  assign O_CHIP_RESET_N = pin_s2_reg.por_n & ~hold_reg & ~rst_cmd_reg;
  assign O_DEBUG_RESET_N = pin_s2_reg.trst_n;

  // ------------------------------------------------------------
  // CPU read of identity halves; no write path exists
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      id_half_reg <= '0;
    end else if (I_ID_HALF_SEL) begin
      id_half_reg <= ID_CODE[ID_HI_LSB +: HALF_W];
    end else begin
      id_half_reg <= ID_CODE[ID_LO_LSB +: HALF_W];
    end
  end

  assign O_ID_HALF = id_half_reg;

endmodule

// File: design/jdt_pkg.sv
// Constants, state codes and carrier types for the debug test port block.
// Assumes one 10 MHz system clock that samples every test-port pin.
package jdt_pkg;

  // ------------------------------------------------------------
  // TAP controller states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PA_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PA_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } jdt_tap_state_type;

  // ------------------------------------------------------------
  // Instruction codes
  // ------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h4;
  localparam logic [IR_W-1:0] INS_DBG_DATA = 4'h5;
  localparam logic [IR_W-1:0] INS_DBG_RST_ON = 4'h6;
  localparam logic [IR_W-1:0] INS_DBG_RST_OFF = 4'h7;
  localparam logic [IR_W-1:0] INS_CLAMP = 4'h8;
  localparam logic [IR_W-1:0] INS_HIGHZ = 4'h9;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // ------------------------------------------------------------
  // Identity and data word layout
  // ------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int ID_LO_LSB = 0;
  localparam int ID_HI_LSB = 16;
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_CTRL = 2;
  localparam int FIFO_DEPTH_DEF = 32;

  // ------------------------------------------------------------
  // Test-port and reset pins, sampled together
  // ------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic por_n;
    logic emu_sel;
  } jdt_pins_type;

  localparam jdt_pins_type PINS_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// File: design/jdt_fifo.sv
// First-word-fall-through FIFO with registered read data.
// Assumes both sides run on the one system clock.
`timescale 1ns/1ns
module jdt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] data_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
  assign o_out_data = data_reg;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= (AW+1)'(count_reg + push - pop);
    end
  end

  // Head word kept in a register; a write to the head slot bypasses
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_reg <= '0;
    end else if (push && (wr_ptr_reg == rd_ptr_next)) begin
      data_reg <= i_in_data;
    end else begin
      data_reg <= mem[rd_ptr_next];
    end
  end

endmodule

// File: bench/jdt_tap_props.sv
// Checker for the debug test port: resets, reset hold, identity halves, TDO enable.
// Bound to jdt_tap; sees only its ports, one system clock domain.
`timescale 1ns/1ns
module jdt_tap_props
  import jdt_pkg::*;
#(
  parameter logic [WORD_W-1:0] ID_CODE = 32'h1000_0001
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_TCK,
  input wire logic I_TRSTN,
  input wire logic O_TDO_OE,
  input wire logic I_POR_PIN_N,
  input wire logic I_EMU_MODE_SEL,
  input wire logic O_CHIP_RESET_N,
  input wire logic O_DEBUG_RESET_N,
  input wire logic O_RESET_HOLD,
  input wire logic I_ID_HALF_SEL,
  input wire logic [HALF_W-1:0] O_ID_HALF
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_trst_lo;
    (!I_TRSTN) [*3];
  endsequence
  sequence s_hold_cause;
    (!I_EMU_MODE_SEL && I_POR_PIN_N && !I_TRSTN) [*3];
  endsequence
  property p_tdo_off;
    !I_TRSTN |-> !O_TDO_OE;
  endproperty
  property p_dbg_lo;
    s_trst_lo |-> !O_DEBUG_RESET_N;
  endproperty
  property p_dbg_hi;
    I_TRSTN [*3] |-> O_DEBUG_RESET_N;
  endproperty
  property p_por;
    (!I_POR_PIN_N) [*3] |-> !O_CHIP_RESET_N;
  endproperty
  property p_hold_set;
    s_hold_cause |-> ##[0:2] O_RESET_HOLD;
  endproperty
  property p_hold_chip;
    O_RESET_HOLD |-> !O_CHIP_RESET_N;
  endproperty
  property p_hold_exit;
    $fell(O_RESET_HOLD) |->
      !$past(I_POR_PIN_N, 2) || !$past(I_POR_PIN_N, 3) || !$past(I_POR_PIN_N, 4);
  endproperty
  property p_tap_step;
    $rose(O_TDO_OE) |-> $past(I_TCK, 2) || $past(I_TCK, 3) || $past(I_TCK, 4);
  endproperty
  property p_id_hi;
    I_ID_HALF_SEL |=> O_ID_HALF[11:0] == ID_CODE[27:16];
  endproperty
  property p_id_lo;
    !I_ID_HALF_SEL |=> O_ID_HALF == ID_CODE[15:0];
  endproperty
  a_tdo_off: assert property (p_tdo_off) else $error("TDO enabled during TRST");
  a_dbg_lo: assert property (p_dbg_lo) else $error("debug reset not applied");
  a_dbg_hi: assert property (p_dbg_hi) else $error("debug reset stuck");
  a_por: assert property (p_por) else $error("chip reset missing on POR");
  a_hold_set: assert property (p_hold_set) else $error("reset hold not entered");
  a_hold_chip: assert property (p_hold_chip) else $error("CPU runs in hold");
  a_hold_exit: assert property (p_hold_exit) else $error("hold left without POR");
  a_tap_step: assert property (p_tap_step) else $error("TAP moved without TCK");
  a_id_hi: assert property (p_id_hi) else $error("identity upper half wrong");
  a_id_lo: assert property (p_id_lo) else $error("identity lower half wrong");
endmodule

// File: bench/jdt_tester.sv
// Tester model for the debug test port: makes TCK, TMS, TDI and TRST.
// Runs off the system clock's falling edge; TCK stands low between frames.
`timescale 1ns/1ns
module jdt_tester #(
  parameter int POR_LOW_CYC = 200
) (
  input wire logic i_clk,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n,
  input wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_n = 1'b1;
  end
  // ----------------------------------------
  // One TCK period, 400 ns per phase
  // ----------------------------------------
  task automatic tick(input logic tms, input logic tdi, output logic lo, output logic hi);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clk);
    lo = i_tdo;
    o_tck = 1'b1;
    repeat (4) @(negedge i_clk);
    hi = i_tdo;
    o_tck = 1'b0;
  endtask
  // IR or DR scan from Run-Test/Idle back to it; LSB first
  task automatic shift(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout, output int diffs);
    logic lo;
    logic hi;
    dout = '0;
    diffs = 0;
    tick(1'b1, o_tdi, lo, hi);
    if (ir) tick(1'b1, o_tdi, lo, hi);
    tick(1'b0, o_tdi, lo, hi);
    tick(1'b0, o_tdi, lo, hi);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], lo, hi);
      dout[i] = lo;
      if (i < n - 1 && lo !== hi) diffs++;
    end
    tick(1'b1, o_tdi, lo, hi);
    tick(1'b0, o_tdi, lo, hi);
  endtask
  task automatic to_idle();
    logic lo;
    logic hi;
    repeat (5) tick(1'b1, o_tdi, lo, hi);
    tick(1'b0, o_tdi, lo, hi);
  endtask
  task automatic trst_pulse();
    o_trst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    o_trst_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic hold_trst(input logic v);
    o_trst_n = v;
  endtask
  task automatic reset_gap();
    repeat (POR_LOW_CYC) @(negedge i_clk);
  endtask
endmodule

// File: bench/jdt_tap_tb_top.sv
// Testbench for jdt_tap: identity, boundary cells, debug reset, FIFO, reset modes.
// Bench drives on the falling clock edge; the tester model drives the TAP pins.
`timescale 1ns/1ns
module jdt_tap_tb_top;
  import jdt_pkg::*;
  // Arbitrary identity value
  localparam logic [WORD_W-1:0] ID_VAL = 32'h0a5c_3e11;
  localparam int NP = 8;
  localparam int CYC_MAX = 30000;
  localparam logic [NP-1:0] P_OUT = 8'h5a;
  localparam logic [NP-1:0] P_CT = 8'hcc;
  logic clk, rstn, tck, tms, tdi, trst_n, tdo, tdo_oe, por_n, emu, chip_n, dbg_n, hold, hsel;
  logic rx_valid, rx_ready;
  logic [HALF_W-1:0] id_half;
  logic [NP-1:0] core_out, core_oe, core_in, pin_in, pin_out, pin_oe, exp_oe, exp_out;
  logic [WORD_W-1:0] rx_data;
  logic [63:0] dout, pre, cap;
  logic [5:0] row;
  logic [3:0] bs_code [4] = '{INS_EXTEST, INS_CLAMP, INS_HIGHZ, INS_BYPASS};
  logic [5:0] modes [9] = '{6'h20, 6'h2a, 6'h34, 6'h3e, 6'h11, 6'h1b, 6'h0a, 6'h1e, 6'h01};
  int diffs;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  // Released TDO line is pulled up
  wire logic tdo_line = tdo_oe ? tdo : 1'b1;

  jdt_tap #(.BSC_PINS(NP), .FIFO_DEPTH(32), .ID_CODE(ID_VAL)) jdt_tap_inst (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
    .I_TRSTN(trst_n), .O_TDO(tdo), .O_TDO_OE(tdo_oe), .I_POR_PIN_N(por_n),
    .I_EMU_MODE_SEL(emu), .O_CHIP_RESET_N(chip_n), .O_DEBUG_RESET_N(dbg_n),
    .O_RESET_HOLD(hold), .I_ID_HALF_SEL(hsel), .O_ID_HALF(id_half),
    .I_CORE_OUT(core_out), .I_CORE_OE(core_oe), .O_CORE_IN(core_in), .I_PIN_IN(pin_in),
    .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_RX_VALID(rx_valid),
    .I_RX_READY(rx_ready), .O_RX_DATA(rx_data)
  );
  jdt_tester #(.POR_LOW_CYC(200)) jdt_tester_inst (
    .i_clk(clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n), .i_tdo(tdo_line)
  );
  // ----------------------------------------
  // Clock, checks, verdict, timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    por_n = 1'b1;
    emu = 1'b1;
    hsel = 1'b0;
    rx_ready = 1'b0;
    core_out = 8'h96;
    core_oe = 8'hf0;
    pin_in = 8'h3c;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    hsel = 1'b1;
    repeat (2) @(negedge clk);
    chk("id_upper", {20'h0, ID_VAL[27:16]}, {20'h0, id_half[11:0]});
    hsel = 1'b0;
    repeat (2) @(negedge clk);
    chk("id_lower", {16'h0, ID_VAL[15:0]}, {16'h0, id_half});
    chk("core_in", 32'(pin_in), 32'(core_in));
    jdt_tester_inst.trst_pulse();
    jdt_tester_inst.to_idle();
    jdt_tester_inst.shift(1'b0, 32, 64'h0, dout, diffs);
    chk("id_tdo", {4'h0, ID_VAL[27:0]}, {4'h0, dout[27:0]});
    chk("std_edge", 32'h0, 32'(diffs));
    pre = '0;
    cap = '0;
    for (int i = 0; i < NP; i++) begin
      pre[3*i +: 3] = {P_CT[i], P_OUT[i], 1'b0};
      cap[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
    end
    jdt_tester_inst.shift(1'b1, 4, {60'h0, INS_SAMPLE}, dout, diffs);
    jdt_tester_inst.shift(1'b0, 3 * NP, pre, dout, diffs);
    chk("bs_capture", cap[31:0], dout[31:0]);
    foreach (bs_code[k]) begin
      jdt_tester_inst.shift(1'b1, 4, {60'h0, bs_code[k]}, dout, diffs);
      exp_oe = (bs_code[k] == INS_HIGHZ) ? '0 : (bs_code[k] == INS_BYPASS) ? core_oe : P_CT;
      exp_out = (bs_code[k] == INS_BYPASS) ? core_out : P_OUT;
      chk("pin_oe", 32'(exp_oe), 32'(pin_oe));
      chk("pin_out", 32'(exp_out & exp_oe), 32'(pin_out & pin_oe));
    end
    jdt_tester_inst.shift(1'b1, 4, {60'h0, INS_DBG_RST_ON}, dout, diffs);
    chk("cmd_rst_on", 32'h0, {31'h0, chip_n});
    jdt_tester_inst.reset_gap();
    chk("cmd_rst_kept", 32'h0, {31'h0, chip_n});
    jdt_tester_inst.shift(1'b1, 4, {60'h0, INS_DBG_RST_OFF}, dout, diffs);
    chk("dbg_edge", 32'h1, {31'h0, diffs != 0});
    chk("cmd_rst_off", 32'h1, {31'h0, chip_n});
    jdt_tester_inst.shift(1'b1, 4, {60'h0, INS_DBG_DATA}, dout, diffs);
    for (int w = 0; w <= 32; w++) begin
      jdt_tester_inst.shift(1'b0, 32, {32'h0, 32'ha5a5_0000 | 32'(w)}, dout, diffs);
      chk("rx_room", {31'h0, w < 32}, {31'h0, dout[0]});
    end
    for (int w = 0; w < 32; w++) begin
      for (int k = 0; k < 20 && rx_valid !== 1'b1; k++) @(negedge clk);
      chk("rx_data", 32'ha5a5_0000 | 32'(w), rx_data);
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
    chk("rx_empty", 32'h0, {31'h0, rx_valid});
    foreach (modes[m]) begin
      row = modes[m];
      emu = row[5];
      por_n = row[4];
      jdt_tester_inst.hold_trst(row[3]);
      repeat (10) @(negedge clk);
      chk("reset_state", 32'(row[2:0]), {29'h0, chip_n, dbg_n, hold});
    end
    give_verdict();
  end
endmodule

bind jdt_tap jdt_tap_props #(.ID_CODE(ID_CODE)) jdt_tap_props_inst (
  .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_TCK(I_TCK), .I_TRSTN(I_TRSTN),
  .O_TDO_OE(O_TDO_OE), .I_POR_PIN_N(I_POR_PIN_N), .I_EMU_MODE_SEL(I_EMU_MODE_SEL),
  .O_CHIP_RESET_N(O_CHIP_RESET_N), .O_DEBUG_RESET_N(O_DEBUG_RESET_N),
  .O_RESET_HOLD(O_RESET_HOLD), .I_ID_HALF_SEL(I_ID_HALF_SEL), .O_ID_HALF(O_ID_HALF)
);
